// ---- verilog/seef_spi_front.sv ----
//
// Contract
// [RULE1] Sample SI on every rising SCK edge, modes (0,0) and (1,1).
// [RULE2] Change SO on each falling SCK edge.
// [RULE3] Select high: SO undriven, standby; running write cycle still finishes.
// [RULE4] Select fall starts a fresh instruction, select rise ends the session.
// [RULE5] Protect pin high adds no restriction on writes.
// [RULE6] Protect pin low with guard bit set refuses status writes.
// [RULE7] Host toggles hold only while SCK is low.
// [RULE8] During hold, partial instruction, address and data position are kept.
// [RULE9] First eight bits after select fall form the instruction byte.
// [RULE10] Undefined instruction bytes are ignored for the whole session.
// [RULE11] 06 sets write enable, 04 clears it, 05 reads status.
// [RULE12] 01 writes status, 03 reads memory, 02 writes memory.
// [RULE13] Memory read: opcode, address, then stored bytes on SO.
// [RULE14] Memory write is rejected unless write enable is set.
// [RULE15] Page-select bit routes reads and writes to the identification page.
// [RULE16] Page-lock bit refuses identification page writes, reads stay allowed.
// [RULE17] Write cycle starts at select rise, standard time 6 ms.
// [RULE18] Fast-write bit shortens the write cycle to 3 ms.
// [RULE19] Host waits 0.1 ms after power-up before any transaction; the testbench selects 8 cycles after reset release.
// [RULE20] Busy bit is 1 during the write cycle, 0 afterwards.
// [RULE21] During the write cycle only the status read is accepted.
// [RULE22] Set-enable sets the enable bit, clear-enable resets it.
// [RULE23] All bytes travel most significant bit first.
// [RULE24] Incomplete sessions are discarded without changing memory or status.
`timescale 1ns/1ps
`default_nettype none
module seef_spi_front
  import seef_pkg::*;
#(
  parameter logic [WC_W-1:0] WC_STD_CYCLES  = WC_STD_CYC,
  parameter logic [WC_W-1:0] WC_FAST_CYCLES = WC_FAST_CYC,
  parameter int              WR_FIFO_DEPTH  = FIFO_DEPTH
)(
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire logic                  sck,
  input  wire logic                  cs_n,
  input  wire logic                  si,
  input  wire logic                  hold_n,
  input  wire logic                  wp_n,
  output logic                       so_o,
  output logic                       so_oe,
  output logic                       rd_req,
  output logic      [MEM_ADDR_W-1:0] rd_addr,
  output logic                       rd_id_page,
  input  wire logic [7:0]            rd_data,
  input  wire logic                  rd_valid,
  output logic                       wr_valid,
  input  wire logic                  wr_ready,
  output seef_wr_s                   wr_item,
  output logic      [7:0]            status_o
);
  seef_pins_s            pin_q;
  seef_state_e           state_reg, state_next;
  seef_stat_s            stat_reg, stat_next;
  seef_wr_s              push_item, push_data_reg, push_data_next;
  logic                  sck_prev_reg, cs_prev_reg;
  logic [7:0]            rx_reg, rx_next, opc_reg, opc_next;
  logic [4:0]            bcnt_reg, bcnt_next;
  logic [MEM_ADDR_W-1:0] addr_reg, addr_next;
  logic                  loaded_reg, loaded_next, ovr_reg, ovr_next;
  logic [7:0]            tx_sr_reg, tx_sr_next, nxt_reg, nxt_next;
  logic [2:0]            tx_cnt_reg, tx_cnt_next;
  logic                  tx_on_reg, tx_on_next, so_reg, so_next;
  logic                  rd_req_reg, rd_req_next;
  logic                  push_pend_reg, push_pend_next, push_req, wc_start;
  logic [WC_W-1:0]       wc_reg, wc_next;
  logic                  fifo_in_ready;
  logic [$bits(seef_wr_s)-1:0] fifo_out;

  seef_sync #(
    .W       ($bits(seef_pins_s)),
    .RST_VAL (PINS_IDLE)
  ) u_sync (
    .mclk    (mclk),
    .reset_n (reset_n),
    .d       ({sck, cs_n, si, hold_n, wp_n}),
    .q       (pin_q)
  );

  seef_fifo #(
    .WIDTH     ($bits(seef_wr_s)),
    .DEPTH     (WR_FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (push_pend_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data_reg),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (fifo_out)
  );

  // Edge detection on the synchronised pins; hold freezes the serial engine
  wire       sel      = ~pin_q.cs_n;
  wire       run      = sel & pin_q.hold_n; // RULE8
  wire       cs_fall  = ~pin_q.cs_n & cs_prev_reg; // RULE4
  wire       cs_rise  = pin_q.cs_n & ~cs_prev_reg;
  wire       sck_rise = run & pin_q.sck & ~sck_prev_reg; // RULE1
  wire       sck_fall = run & ~pin_q.sck & sck_prev_reg; // RULE2
  wire [7:0] rx_in    = {rx_reg[6:0], pin_q.si}; // RULE23

  // Write permission and instruction decode
  wire       wen      = stat_reg.write_enable_latch_bit;
  wire       mem_ok   = wen & ~(stat_reg.id_page_select_bit & stat_reg.id_page_lock_bit); // RULE14 RULE16
  wire       pin_lock = ~pin_q.wp_n & stat_reg.guard_pin_enable_bit; // RULE5 RULE6
  wire       stat_ok  = wen & ~pin_lock;
  wire       is_read  = (opc_reg == OPC_MEM_RD);
  seef_state_e dec_state;
  assign dec_state =
    (stat_reg.busy && rx_in != OPC_STAT_RD) ? ST_IGNORE : // RULE21
    (rx_in == OPC_SET_WEN || rx_in == OPC_CLR_WEN) ? ST_LATCH : // RULE11
    (rx_in == OPC_STAT_RD) ? ST_OUT :
    (rx_in == OPC_STAT_WR) ? (stat_ok ? ST_SWR : ST_IGNORE) : // RULE12
    (rx_in == OPC_MEM_RD) ? ST_ADDR :
    (rx_in == OPC_MEM_WR) ? (mem_ok ? ST_ADDR : ST_IGNORE) :
    ST_IGNORE; // RULE10

  // Identification page wraps within its 256 bytes, the array over its full range
  wire [MEM_ADDR_W-1:0] addr_inc = stat_reg.id_page_select_bit
    ? {addr_reg[MEM_ADDR_W-1:8], addr_reg[7:0] + 8'h01}
    : addr_reg + 1'b1;
  wire [7:0] tx_src = is_read ? nxt_reg : stat_reg;
  wire [7:0] sw_val = rx_reg;
  wire       sw_both = sw_val[6] & sw_val[4];

  always_comb
  begin
    state_next     = state_reg;
    stat_next      = stat_reg;
    rx_next        = rx_reg;
    opc_next       = opc_reg;
    bcnt_next      = bcnt_reg;
    addr_next      = addr_reg;
    loaded_next    = loaded_reg;
    ovr_next       = ovr_reg;
    tx_sr_next     = tx_sr_reg;
    tx_cnt_next    = tx_cnt_reg;
    tx_on_next     = tx_on_reg;
    so_next        = so_reg;
    nxt_next       = rd_valid ? rd_data : nxt_reg;
    rd_req_next    = 1'b0;
    push_req       = 1'b0;
    push_item      = '0;
    wc_start       = 1'b0;
    push_pend_next = push_pend_reg;
    push_data_next = push_data_reg;
    wc_next        = wc_reg;
    if (cs_fall)
    begin
      state_next  = ST_OPC; // RULE4
      bcnt_next   = '0;
      loaded_next = 1'b0;
      ovr_next    = 1'b0;
      tx_on_next  = 1'b0;
      tx_cnt_next = '0;
    end
    else if (cs_rise)
    begin
      state_next = ST_IDLE;
      tx_on_next = 1'b0; // RULE3
      case (state_reg)
        ST_LATCH:
        begin
          if (opc_reg == OPC_SET_WEN)
            stat_next.write_enable_latch_bit = 1'b1; // RULE22
          else if (opc_reg == OPC_CLR_WEN)
            stat_next.write_enable_latch_bit = 1'b0; // RULE22
          else
          begin
            stat_next.guard_pin_enable_bit  = sw_val[7];
            stat_next.fast_write_select_bit = sw_val[5];
            stat_next.block_protect         = sw_val[3:2];
            if (!sw_both)
            begin
              stat_next.id_page_select_bit = sw_val[6];
              stat_next.id_page_lock_bit   = stat_reg.id_page_lock_bit | sw_val[4];
            end
            wc_start = 1'b1; // RULE17
          end
        end
        ST_WDATA:
        begin
          if (loaded_reg)
          begin
            push_req = 1'b1;
            if (bcnt_reg == '0 && !ovr_reg)
            begin
              push_item.op                 = WOP_COMMIT;
              wc_start                     = 1'b1; // RULE17
              stat_next.id_page_select_bit = 1'b0;
            end
            else
              push_item.op = WOP_ABORT; // RULE24
          end
        end
        ST_OUT:
        begin
          if (is_read)
            stat_next.id_page_select_bit = 1'b0;
        end
        default:
        begin
        end
      endcase
    end
    else if (sck_rise)
    begin
      rx_next   = rx_in; // RULE1
      bcnt_next = bcnt_reg + 1'b1;
      case (state_reg)
        ST_OPC:
        begin
          if (bcnt_reg == BYTE_LAST_BIT)
          begin
            opc_next   = rx_in; // RULE9
            bcnt_next  = '0;
            state_next = dec_state;
          end
        end
        ST_ADDR:
        begin
          addr_next = {addr_reg[MEM_ADDR_W-2:0], pin_q.si}; // RULE23
          if (bcnt_reg == ADDR_LAST_BIT)
          begin
            bcnt_next   = '0;
            state_next  = is_read ? ST_OUT : ST_WDATA;
            rd_req_next = is_read; // RULE13
          end
        end
        ST_WDATA:
        begin
          if (bcnt_reg == BYTE_LAST_BIT)
          begin
            bcnt_next         = '0;
            push_req          = 1'b1;
            push_item.op      = WOP_LOAD;
            push_item.id_page = stat_reg.id_page_select_bit; // RULE15
            push_item.addr    = addr_reg;
            push_item.data    = rx_in;
            loaded_next       = 1'b1;
            addr_next         = {addr_reg[MEM_ADDR_W-1:8], addr_reg[7:0] + 8'h01};
          end
        end
        ST_SWR:
        begin
          if (bcnt_reg == BYTE_LAST_BIT)
            state_next = ST_LATCH;
        end
        ST_LATCH:
          state_next = ST_IGNORE; // RULE24
        default:
        begin
        end
      endcase
    end
    else if (sck_fall && state_reg == ST_OUT)
    begin
      tx_on_next = 1'b1;
      if (tx_cnt_reg == '0)
      begin
        so_next     = tx_src[7]; // RULE2
        tx_sr_next  = {tx_src[6:0], 1'b0};
        tx_cnt_next = TX_LAST_BIT;
        if (is_read)
        begin
          addr_next   = addr_inc;
          rd_req_next = 1'b1; // RULE13
        end
      end
      else
      begin
        so_next     = tx_sr_reg[7]; // RULE23
        tx_sr_next  = {tx_sr_reg[6:0], 1'b0};
        tx_cnt_next = tx_cnt_reg - 1'b1;
      end
    end
    // Staging register in front of the write FIFO
    if (push_req)
    begin
      if (push_pend_reg && !fifo_in_ready)
        ovr_next = 1'b1;
      else
      begin
        push_pend_next = 1'b1;
        push_data_next = push_item;
      end
    end
    else if (fifo_in_ready)
      push_pend_next = 1'b0;
    // Self-timed write cycle
    if (wc_start)
    begin
      stat_next.busy = 1'b1; // RULE20
      wc_next = stat_reg.fast_write_select_bit ? WC_FAST_CYCLES : WC_STD_CYCLES; // RULE18
    end
    else if (stat_reg.busy)
    begin
      wc_next = wc_reg - 1'b1;
      if (wc_reg <= {{(WC_W-1){1'b0}}, 1'b1})
      begin
        stat_next.busy                   = 1'b0; // RULE20
        stat_next.write_enable_latch_bit = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      state_reg     <= ST_IDLE;
      stat_reg      <= STATUS_RST;
      sck_prev_reg  <= PINS_IDLE[4];
      cs_prev_reg   <= PINS_IDLE[3];
      rx_reg        <= '0;
      opc_reg       <= '0;
      bcnt_reg      <= '0;
      addr_reg      <= '0;
      loaded_reg    <= 1'b0;
      ovr_reg       <= 1'b0;
      tx_sr_reg     <= '0;
      tx_cnt_reg    <= '0;
      tx_on_reg     <= 1'b0;
      so_reg        <= 1'b0;
      nxt_reg       <= '0;
      rd_req_reg    <= 1'b0;
      push_pend_reg <= 1'b0;
      push_data_reg <= '0;
      wc_reg        <= '0;
    end
    else
    begin
      state_reg     <= state_next;
      stat_reg      <= stat_next;
      sck_prev_reg  <= pin_q.sck;
      cs_prev_reg   <= pin_q.cs_n;
      rx_reg        <= rx_next;
      opc_reg       <= opc_next;
      bcnt_reg      <= bcnt_next;
      addr_reg      <= addr_next;
      loaded_reg    <= loaded_next;
      ovr_reg       <= ovr_next;
      tx_sr_reg     <= tx_sr_next;
      tx_cnt_reg    <= tx_cnt_next;
      tx_on_reg     <= tx_on_next;
      so_reg        <= so_next;
      nxt_reg       <= nxt_next;
      rd_req_reg    <= rd_req_next;
      push_pend_reg <= push_pend_next;
      push_data_reg <= push_data_next;
      wc_reg        <= wc_next;
    end
  end

  assign so_o       = so_reg;
  assign so_oe      = run & tx_on_reg; // RULE3
  assign rd_req     = rd_req_reg;
  assign rd_addr    = addr_reg;
  assign rd_id_page = stat_reg.id_page_select_bit; // RULE15
  assign wr_item    = fifo_out;
  assign status_o   = stat_reg;
endmodule
`default_nettype wire

// ---- verilog/seef_pkg.sv ----
`default_nettype none
package seef_pkg;
  // Clock and write-cycle timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS     = 1000000;
  localparam int TWC_STD_MS    = 6;
  localparam int TWC_FAST_MS   = 3;
  localparam int WC_W          = 20;
  localparam logic [WC_W-1:0] WC_STD_CYC  = WC_W'(TWC_STD_MS * NS_PER_MS / CLK_PERIOD_NS);
  localparam logic [WC_W-1:0] WC_FAST_CYC = WC_W'(TWC_FAST_MS * NS_PER_MS / CLK_PERIOD_NS);

  // Instruction codes
  localparam logic [7:0] OPC_SET_WEN = 8'h06;
  localparam logic [7:0] OPC_CLR_WEN = 8'h04;
  localparam logic [7:0] OPC_STAT_RD = 8'h05;
  localparam logic [7:0] OPC_STAT_WR = 8'h01;
  localparam logic [7:0] OPC_MEM_RD  = 8'h03;
  localparam logic [7:0] OPC_MEM_WR  = 8'h02;

  // Frame counts
  localparam logic [4:0] BYTE_LAST_BIT = 5'h07;
  localparam logic [4:0] ADDR_LAST_BIT = 5'h17;
  localparam logic [2:0] TX_LAST_BIT   = 3'h7;
  localparam int         MEM_ADDR_W    = 18;
  localparam int         FIFO_DEPTH    = 8;

  // Status byte, bit 7 down to bit 0
  typedef struct packed {
    logic       guard_pin_enable_bit;
    logic       id_page_select_bit;
    logic       fast_write_select_bit;
    logic       id_page_lock_bit;
    logic [1:0] block_protect;
    logic       write_enable_latch_bit;
    logic       busy;
  } seef_stat_s;
  localparam logic [7:0] STATUS_RST = 8'h00;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
    logic hold_n;
    logic wp_n;
  } seef_pins_s;
  localparam logic [4:0] PINS_IDLE = 5'h0B;

  typedef enum logic [1:0] {
    WOP_LOAD   = 2'h0,
    WOP_COMMIT = 2'h1,
    WOP_ABORT  = 2'h2
  } seef_wop_e;

  typedef struct packed {
    seef_wop_e             op;
    logic                  id_page;
    logic [MEM_ADDR_W-1:0] addr;
    logic [7:0]            data;
  } seef_wr_s;

  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_OPC    = 8'h02,
    ST_LATCH  = 8'h04,
    ST_ADDR   = 8'h08,
    ST_WDATA  = 8'h10,
    ST_SWR    = 8'h20,
    ST_OUT    = 8'h40,
    ST_IGNORE = 8'h80
  } seef_state_e;
endpackage
`default_nettype wire

// ---- verilog/seef_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module seef_sync
  import seef_pkg::*;
#(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
)(
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/seef_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module seef_fifo
  import seef_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_DEPTH
)(
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [AW:0]      cnt_reg;
  wire              do_in  = in_valid & in_ready;
  wire              do_out = out_valid & out_ready;
  wire  [AW-1:0]    wptr_inc = (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
  wire  [AW-1:0]    rptr_inc = (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;

  assign in_ready  = (cnt_reg != (AW + 1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_q[rptr_reg];

  always_ff @(posedge mclk)
  begin
    if (do_in)
      mem_q[wptr_reg] <= in_data;
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
    end
    else
    begin
      if (do_in)
        wptr_reg <= wptr_inc;
      if (do_out)
        rptr_reg <= rptr_inc;
      if (do_in && !do_out)
        cnt_reg <= cnt_reg + 1'b1;
      else if (do_out && !do_in)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- test/seef_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module seef_host
  import seef_pkg::*;
(
  input  wire logic mclk,
  input  wire logic so_o,
  input  wire logic so_oe,
  output var  seef_pins_s pins
);
  logic        mode3   = 1'b0;
  int          hold_at = -1;
  logic        so_n    = 1'b1;
  logic [63:0] rx;
  wire         so_line = so_oe ? so_o : so_n;
  initial pins = PINS_IDLE;
  // A released line toggles every cycle, starting from the inverse of the last driven bit
  always @(posedge mclk) so_n <= ~so_line;
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Sends nb bits of tx, MSB first, and captures SO at each rise
  task automatic frame(input int nb, input logic [63:0] tx);
    int i;
    rx = '0;
    pins.sck = mode3;
    wait_n(8);
    pins.cs_n = 1'b0;
    wait_n(8);
    for (i = nb - 1; i >= 0; i--)
    begin
      pins.sck = 1'b0;
      pins.si = tx[i];
      wait_n(8);
      if (nb - 1 - i == hold_at)
      begin
        pins.hold_n = 1'b0;
        wait_n(24);
        pins.hold_n = 1'b1;
        wait_n(8);
      end
      pins.sck = 1'b1;
      rx = {rx[62:0], so_line};
      wait_n(8);
    end
    pins.sck = mode3;
    wait_n(8);
    pins.cs_n = 1'b1;
    wait_n(16);
  endtask
endmodule
`default_nettype wire

// ---- test/seef_spi_front_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module seef_spi_front_chk
  import seef_pkg::*;
#(
  parameter logic [WC_W-1:0] WC_STD_CYCLES  = WC_STD_CYC,
  parameter logic [WC_W-1:0] WC_FAST_CYCLES = WC_FAST_CYC
)(
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic       sck,
  input wire logic       cs_n,
  input wire logic       hold_n,
  input wire logic       so_o,
  input wire logic       so_oe,
  input wire logic       rd_req,
  input wire logic       wr_valid,
  input wire logic       wr_ready,
  input wire seef_wr_s   wr_item,
  input wire logic [7:0] status_o
);
  logic [WC_W-1:0] busy_cnt_reg;
  always_ff @(posedge mclk)
    if (!reset_n) busy_cnt_reg <= '0;
    else busy_cnt_reg <= status_o[0] ? busy_cnt_reg + 1'b1 : '0;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_so_idle; cs_n [*3] |-> !so_oe; endproperty
  a_so_idle: assert property (p_so_idle) else $error("so driven while deselected");
  property p_hold; !hold_n [*4] |-> !so_oe && $stable(so_o); endproperty
  a_hold: assert property (p_hold) else $error("so active during hold");
  property p_so_fall; $changed(so_o) |-> !$past(sck, 1) && !$past(sck, 3); endproperty
  a_so_fall: assert property (p_so_fall) else $error("so moved off a clock fall");
  property p_oe_rise; $rose(so_oe) |-> !$past(sck, 1) && !cs_n && hold_n; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("so enabled at wrong time");
  property p_rd; rd_req |-> !$past(cs_n, 3) ##1 !rd_req; endproperty
  a_rd: assert property (p_rd) else $error("bad read request");
  property p_busy_go; $rose(status_o[0]) |-> $past(cs_n, 1) && $past(cs_n, 3); endproperty
  a_busy_go: assert property (p_busy_go) else $error("busy not at select rise");
  property p_busy_len;
    $fell(status_o[0]) |-> busy_cnt_reg == WC_STD_CYCLES || busy_cnt_reg == WC_FAST_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  property p_wen_end; $fell(status_o[0]) |-> !status_o[1]; endproperty
  a_wen_end: assert property (p_wen_end) else $error("enable kept after cycle");
  property p_wen_cs; $changed(status_o[1]) |-> $past(cs_n, 1) || $fell(status_o[0]); endproperty
  a_wen_cs: assert property (p_wen_cs) else $error("enable moved in session");
  property p_busy_wen; status_o[0] |-> status_o[1]; endproperty
  a_busy_wen: assert property (p_busy_wen) else $error("enable lost during cycle");
  property p_fifo; wr_valid && !wr_ready |=> wr_valid && $stable(wr_item); endproperty
  a_fifo: assert property (p_fifo) else $error("write item not held");
  c_fast: cover property ($fell(status_o[0]) && busy_cnt_reg == WC_FAST_CYCLES);
  c_rd: cover property (rd_req);
  c_stall: cover property (wr_valid && !wr_ready);
endmodule
bind seef_spi_front seef_spi_front_chk #(
  .WC_STD_CYCLES(WC_STD_CYCLES),
  .WC_FAST_CYCLES(WC_FAST_CYCLES)
) u_chk (
  .mclk(mclk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .hold_n(hold_n),
  .so_o(so_o), .so_oe(so_oe), .rd_req(rd_req), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .wr_item(wr_item), .status_o(status_o)
);
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  import seef_pkg::*;
  localparam logic [WC_W-1:0] STD = 20'h004B0;
  localparam logic [WC_W-1:0] FST = 20'h00258;
  logic                  mclk     = 1'b0;
  logic                  reset_n  = 1'b0;
  logic                  stall    = 1'b0;
  logic                  rd_valid = 1'b0;
  logic [7:0]            rd_data  = 8'h00;
  logic [2:0]            rd_pipe  = 3'h0;
  logic [MEM_ADDR_W-1:0] ra       = '0;
  logic                  ri       = 1'b0;
  logic                  so_o, so_oe, rd_req, rd_id_page, wr_valid;
  logic [MEM_ADDR_W-1:0] rd_addr;
  logic [7:0]            status_o;
  seef_wr_s              wr_item;
  seef_pins_s            pins;
  seef_wr_s              items[$];
  seef_wr_s              exp_q[$];
  int                    mismatches = 0;
  int                    n_tests    = 0;
  int                    blen       = 0;
  int                    last_len   = 0;
  seef_host host (.mclk(mclk), .so_o(so_o), .so_oe(so_oe), .pins(pins));
  seef_spi_front #(.WC_STD_CYCLES(STD), .WC_FAST_CYCLES(FST)) DUT (
    .mclk(mclk), .reset_n(reset_n), .sck(pins.sck), .cs_n(pins.cs_n), .si(pins.si),
    .hold_n(pins.hold_n), .wp_n(pins.wp_n), .so_o(so_o), .so_oe(so_oe), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_id_page(rd_id_page), .rd_data(rd_data), .rd_valid(rd_valid),
    .wr_valid(wr_valid), .wr_ready(!stall), .wr_item(wr_item), .status_o(status_o));
  initial forever #5 mclk = ~mclk;
  function automatic logic [7:0] mem(input logic [MEM_ADDR_W-1:0] a, input logic id);
    return a[7:0] ^ {id, 7'h3C};
  endfunction
  // Memory answers three cycles after each request; consumer pops unless stalled
  always @(posedge mclk)
  begin
    rd_pipe <= {rd_pipe[1:0], rd_req};
    if (rd_req)
    begin
      ra <= rd_addr;
      ri <= rd_id_page;
    end
    rd_valid <= rd_pipe[1];
    rd_data <= mem(ra, ri);
    if (reset_n && wr_valid === 1'b1 && !stall) items.push_back(wr_item);
    if (status_o[0] === 1'b1) blen <= blen + 1;
    else if (blen != 0)
    begin
      last_len <= blen;
      blen <= 0;
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk_items();
    chk("items", items.size(), exp_q.size());
    foreach (exp_q[i])
      if (i < items.size()) chk("item", items[i], exp_q[i]);
    items.delete();
  endtask
  task automatic run(input int nb, input logic [63:0] tx);
    host.frame(nb, tx);
  endtask
  task automatic wbusy();
    int n;
    n = 0;
    while (status_o[0] !== 1'b0 && n < 2000)
    begin
      @(negedge mclk);
      n++;
    end
    host.wait_n(4);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge mclk);
    reset_n = 1'b1;
    chk("status reset", status_o, STATUS_RST);
    chk("oe reset", {so_oe, wr_valid, rd_req}, 3'h0);
    $display("test reset done");
    run(8, 8'h06);
    chk("enable set", status_o, 8'h02);
    host.mode3 = 1'b1;
    host.hold_at = 12;
    run(24, 24'h050000);
    chk("status read", host.rx[15:0], 16'h0202);
    host.mode3 = 1'b0;
    host.hold_at = -1;
    run(8, 8'h04);
    chk("enable clear", status_o, 8'h00);
    $display("test enable done");
    run(16, 16'hA506);
    run(9, 9'h00C);
    run(40, 40'h020000105A);
    chk("refusals", {status_o, wr_valid}, 9'h000);
    $display("test refuse done");
    stall = 1'b1;
    run(8, 8'h06);
    run(48, 48'h020000105A3C);
    chk("fifo held", wr_valid, 1'b1);
    run(8, 8'h04);
    chk("ignored in cycle", status_o, 8'h03);
    run(16, 16'h0500);
    chk("busy read", host.rx[7:0], 8'h03);
    stall = 1'b0;
    wbusy();
    chk("std cycle", last_len, STD);
    chk("after cycle", status_o, 8'h00);
    exp_q = '{seef_wr_s'{WOP_LOAD, 1'b0, 18'h00010, 8'h5A},
              seef_wr_s'{WOP_LOAD, 1'b0, 18'h00011, 8'h3C},
              seef_wr_s'{WOP_COMMIT, 1'b0, 18'h00000, 8'h00}};
    chk_items();
    $display("test write done");
    run(8, 8'h06);
    run(16, 16'h01A0);
    wbusy();
    chk("status write", status_o, 8'hA0);
    host.pins.wp_n = 1'b0;
    run(8, 8'h06);
    run(16, 16'h0100);
    chk("guarded", status_o, 8'hA2);
    host.pins.wp_n = 1'b1;
    run(16, 16'h01E0);
    wbusy();
    chk("unguarded", status_o, 8'hE0);
    run(48, 48'h030000050000);
    chk("id read", host.rx[15:0], {mem(18'h5, 1'b1), mem(18'h6, 1'b1)});
    run(8, 8'h06);
    run(16, 16'h01E0);
    wbusy();
    run(8, 8'h06);
    run(40, 40'h0200000777);
    wbusy();
    chk("fast cycle", last_len, FST);
    exp_q = '{seef_wr_s'{WOP_LOAD, 1'b1, 18'h00007, 8'h77},
              seef_wr_s'{WOP_COMMIT, 1'b0, 18'h00000, 8'h00}};
    chk_items();
    $display("test id page done");
    run(8, 8'h06);
    run(16, 16'h01B0);
    wbusy();
    run(8, 8'h06);
    run(16, 16'h01E0);
    wbusy();
    chk("locked", status_o, 8'hF0);
    run(8, 8'h06);
    run(40, 40'h0200000199);
    chk("lock refuse", {status_o, wr_valid}, 9'h1E4);
    run(40, 40'h0300000100);
    chk("lock read", host.rx[7:0], mem(18'h1, 1'b1));
    run(48, 48'h030001230000);
    chk("main read", host.rx[15:0], {mem(18'h123, 1'b0), mem(18'h124, 1'b0)});
    $display("test lock done");
    results();
  end
  initial
  begin
    repeat (90000) @(negedge mclk);
    mismatches++;
    results();
  end
endmodule
`default_nettype wire
